// [board_ctrl_pkg.sv]
// Package with constants and state types for the board control block
package board_ctrl_pkg;
  // Board clock rate in kHz
  localparam int CLOCK_KHZ = 40000;
  // Contact bounce window in microseconds
  localparam int DEBOUNCE_US = 10000;
  // Debounce window in clock cycles (rounded up)
  localparam int DEBOUNCE_CYCLES = (DEBOUNCE_US * CLOCK_KHZ + 999) / 1000;
  // Reset pulse length in nanoseconds
  localparam int RESET_PULSE_NS = 1000;
  // Reset pulse length in clock cycles (rounded up, period 25 ns)
  localparam int RESET_PULSE_CYCLES = (RESET_PULSE_NS + 24) / 25;
  // Width of the timers
  localparam int TIMER_W = 20;
  // Number of software option switches
  localparam int OPTION_W = 4;
  // Width of a configuration word
  localparam int CONFIG_W = 32;
  // Jumper setting that selects the freeze line
  localparam logic JUMPER_FREEZE = 1'h1;

  // Reset sequencer states
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_SOFT = 2'b01,
    ST_HARD = 2'b10,
    ST_WAIT = 2'b11
  } reset_state_e;
endpackage : board_ctrl_pkg

// [board_switch_reset_indicator_ctrl.sv]
// Board control: push-buttons, resets, option lines, indicators, buffers
// Function
// - Abort button raises level 0 interrupt
// - Abort debounced, never maskable by software
// - Soft button alone issues soft reset
// - Soft reset debounced, never disabled by software
// - Soft config word sampled at sequence end
// - Both buttons pressed issue hard reset
// - Hard end presents first register config
// - Four option switches readable via registers
// - Run lit only outside debug mode
// - Auxiliary indicator follows signal lamp bit
// - Flash enable routes chip select and lamp
// - DRAM enable routes two selects, lamp
// - SDRAM enable routes chip select and lamp
// - Card enabled drives address, status, lamp
// - Card data driven only during card enable
// - Card disabled tri-states all buffers, lamp dark
// - Transceivers shut down when disabled, lamp active
`timescale 1ns/10ps
module board_switch_reset_indicator_ctrl
  import board_ctrl_pkg::*;
#(
  parameter int DEBOUNCE_LEN = DEBOUNCE_CYCLES,
  parameter int PULSE_LEN = RESET_PULSE_CYCLES,
  parameter int XCVR_N = 4
) (
  input wire logic clock,
  input wire logic sys_rst,
  // Raw buttons, high while pressed
  input wire logic abort_button,
  input wire logic soft_reset_button,
  // Option switch states
  input wire logic [OPTION_W-1:0] software_option_switches,
  // Debug state from the processor
  input wire logic debug_status_line_a,
  input wire logic debug_status_line_b,
  input wire logic freeze_line,
  input wire logic debug_source_jumper,
  // Register bits from the board control/status registers
  input wire logic [CONFIG_W-1:0] board_ctrl_reg_first,
  input wire logic flash_enable,
  input wire logic dram_enable,
  input wire logic sdram_enable,
  input wire logic pcmcia_enable,
  input wire logic signal_lamp,
  input wire logic [XCVR_N-1:0] xcvr_enable,
  input wire logic [CONFIG_W-1:0] soft_config_word,
  // Processor chip selects and card strobes
  input wire logic cs0_cpu_n,
  input wire logic cs2_cpu_n,
  input wire logic cs3_cpu_n,
  input wire logic cs4_cpu_n,
  input wire logic card_enable_low_n,
  input wire logic card_enable_high_n,
  input wire logic card_write_n,
  // Outputs toward the processor
  output logic abort_irq0_n,
  output logic soft_reset_n,
  output logic hard_reset_n,
  output logic [CONFIG_W-1:0] config_word,
  output logic config_valid,
  output logic [OPTION_W-1:0] option_switch_lines,
  // Memory chip selects
  output logic chip_select_flash_n,
  output logic chip_select_dram_a_n,
  output logic chip_select_dram_b_n,
  output logic chip_select_sdram_n,
  // Card buffer enables, low while driving; data direction high toward the card
  output logic card_addr_buf_oe_n,
  output logic card_status_buf_oe_n,
  output logic card_data_buf_oe_n,
  output logic card_data_to_card,
  // Transceiver shutdown, high while shut down
  output logic [XCVR_N-1:0] xcvr_shutdown,
  // Indicators, high while lit
  output logic run_indicator,
  output logic auxiliary_indicator,
  output logic flash_indicator,
  output logic dram_indicator,
  output logic sdram_indicator,
  output logic pcmcia_indicator,
  output logic [XCVR_N-1:0] xcvr_indicator
);

  // All state of the block
  typedef struct packed {
    logic abort_db;                 // Debounced abort level
    logic soft_db;                  // Debounced soft level
    logic [TIMER_W-1:0] abort_cnt;  // Abort stability counter
    logic [TIMER_W-1:0] soft_cnt;   // Soft stability counter
    reset_state_e state;            // Reset sequencer state
    logic [TIMER_W-1:0] pulse_cnt;  // Reset pulse timer
    logic irq;                      // Abort request level
    logic [CONFIG_W-1:0] cfg;       // Presented configuration
    logic cfg_valid;                // Configuration valid flag
    logic [OPTION_W-1:0] opt;       // Registered option lines
  } state_s;

  state_s state_reg;
  state_s state_next;

  // Last debounce count (length minus one) as a timer-width constant
  localparam logic [TIMER_W-1:0] DB_LAST = TIMER_W'(DEBOUNCE_LEN - 1);
  // Last reset pulse count (length minus one) as a timer-width constant
  localparam logic [TIMER_W-1:0] PULSE_LAST = TIMER_W'(PULSE_LEN - 1);
  localparam logic [TIMER_W-1:0] TIMER_ZERO = '0;
  localparam logic [TIMER_W-1:0] TIMER_ONE = TIMER_W'(1);

  // Debounce step: count while raw differs from accepted, else restart
  function automatic logic [TIMER_W-1:0] db_count(
    input logic raw,
    input logic accepted,
    input logic [TIMER_W-1:0] cnt
  );
    if (raw == accepted) begin
      db_count = TIMER_ZERO;
    end else if (cnt == DB_LAST) begin
      db_count = TIMER_ZERO;
    end else begin
      db_count = cnt + TIMER_ONE;
    end
  endfunction : db_count

  // Accepted level flips when the differing level lasted the window
  function automatic logic db_level(
    input logic raw,
    input logic accepted,
    input logic [TIMER_W-1:0] cnt
  );
    db_level = (raw != accepted && cnt == DB_LAST) ? raw : accepted;
  endfunction : db_level

  logic both_pressed;

  // Next state: debouncers, reset sequencer, config presentation
  always_comb begin
    state_next = state_reg;
    both_pressed = 1'h0;
    // Both buttons are filtered alike; no software gate exists
    state_next.abort_cnt = db_count(abort_button, state_reg.abort_db,
                                    state_reg.abort_cnt);
    state_next.abort_db = db_level(abort_button, state_reg.abort_db,
                                   state_reg.abort_cnt);
    state_next.soft_cnt = db_count(soft_reset_button, state_reg.soft_db,
                                   state_reg.soft_cnt);
    state_next.soft_db = db_level(soft_reset_button, state_reg.soft_db,
                                  state_reg.soft_cnt);
    both_pressed = state_reg.abort_db && state_reg.soft_db;
    // Abort interrupt only for a lone abort press
    state_next.irq = state_reg.abort_db && !state_reg.soft_db &&
                     state_reg.state == ST_IDLE;
    // Options copied every cycle for register readback
    state_next.opt = software_option_switches;
    unique case (state_reg.state)
      ST_IDLE: begin
        if (both_pressed) begin
          // Hard reset takes precedence over the lone actions
          state_next.state = ST_HARD;
          state_next.pulse_cnt = TIMER_ZERO;
          state_next.cfg_valid = 1'h0;
          state_next.irq = 1'h0;
        end else if (state_reg.soft_db) begin
          state_next.state = ST_SOFT;
          state_next.pulse_cnt = TIMER_ZERO;
          // Old configuration is void until the pulse ends
          state_next.cfg_valid = 1'h0;
        end
      end
      ST_SOFT: begin
        if (both_pressed) begin
          // Late abort during a soft pulse escalates to hard
          state_next.state = ST_HARD;
          state_next.pulse_cnt = TIMER_ZERO;
        end else if (state_reg.pulse_cnt == PULSE_LAST) begin
          // Sample soft config at the end of the sequence
          state_next.cfg = soft_config_word;
          state_next.cfg_valid = 1'h1;
          state_next.state = ST_WAIT;
        end else begin
          state_next.pulse_cnt = state_reg.pulse_cnt + TIMER_ONE;
        end
      end
      ST_HARD: begin
        if (state_reg.pulse_cnt == PULSE_LAST) begin
          state_next.cfg = board_ctrl_reg_first;
          state_next.cfg_valid = 1'h1;
          state_next.state = ST_WAIT;
        end else begin
          state_next.pulse_cnt = state_reg.pulse_cnt + TIMER_ONE;
        end
      end
      ST_WAIT: begin
        // One action per press: wait until both are released
        if (!state_reg.abort_db && !state_reg.soft_db) begin
          state_next.state = ST_IDLE;
        end
      end
    endcase
  end

  // State register
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  // Reset and interrupt outputs, active low toward the processor
  assign abort_irq0_n = !state_reg.irq;
  assign soft_reset_n = !(state_reg.state == ST_SOFT);
  assign hard_reset_n = !(state_reg.state == ST_HARD);
  assign config_word = state_reg.cfg;
  assign config_valid = state_reg.cfg_valid;
  assign option_switch_lines = state_reg.opt;

  // Debug mode chooses between status pair and freeze line
  logic in_debug;
  assign in_debug = (debug_source_jumper == JUMPER_FREEZE) ? freeze_line :
                    (debug_status_line_a || debug_status_line_b);
  assign run_indicator = !in_debug;
  assign auxiliary_indicator = signal_lamp;

  // Chip select steering; released selects stay high on-board
  assign chip_select_flash_n = flash_enable ? cs0_cpu_n : 1'h1;
  assign flash_indicator = flash_enable;
  assign chip_select_dram_a_n = dram_enable ? cs2_cpu_n : 1'h1;
  assign chip_select_dram_b_n = dram_enable ? cs3_cpu_n : 1'h1;
  assign dram_indicator = dram_enable;
  assign chip_select_sdram_n = sdram_enable ? cs4_cpu_n : 1'h1;
  assign sdram_indicator = sdram_enable;

  // Card buffers; disabled channel tri-states all of them
  logic card_strobe;
  assign card_strobe = !card_enable_low_n || !card_enable_high_n;
  assign card_addr_buf_oe_n = !pcmcia_enable;
  assign card_status_buf_oe_n = !pcmcia_enable;
  assign card_data_buf_oe_n = !(pcmcia_enable && card_strobe);
  assign card_data_to_card = !card_write_n;
  assign pcmcia_indicator = pcmcia_enable;

  // Transceivers: shutdown when disabled, lamp while active
  assign xcvr_shutdown = ~xcvr_enable;
  assign xcvr_indicator = xcvr_enable;

  // Checks on the push-button and reset sequencer side
  // Hard and soft reset pulses never overlap
  chk_hard_wins: assert property (
    @(posedge clock) disable iff (sys_rst)
    !(!hard_reset_n && !soft_reset_n))
    else $error("hard and soft reset together");
  // Interrupt only follows a lone accepted abort press
  chk_irq_lone: assert property (
    @(posedge clock) disable iff (sys_rst)
    !abort_irq0_n |-> $past(state_reg.abort_db && !state_reg.soft_db))
    else $error("abort irq without lone abort");
  // Pulse must be long enough for the processor to see it
  chk_hard_len: assert property (
    @(posedge clock) disable iff (sys_rst)
    $fell(hard_reset_n) |-> !hard_reset_n [*8])
    else $error("hard reset pulse too short");
  // Hard configuration presented as the pulse ends
  chk_hard_cfg: assert property (
    @(posedge clock) disable iff (sys_rst)
    $rose(hard_reset_n) |-> config_valid &&
    config_word == $past(board_ctrl_reg_first))
    else $error("hard config not presented");
  // Soft configuration sampled as the pulse ends
  chk_soft_cfg: assert property (
    @(posedge clock) disable iff (sys_rst)
    $rose(soft_reset_n) && $past(state_reg.state) == ST_SOFT &&
    state_reg.state == ST_WAIT |->
    config_word == $past(soft_config_word))
    else $error("soft config not sampled");
  // Accepted abort level only ever moves toward the raw abort level
  chk_db_hold: assert property (
    @(posedge clock) disable iff (sys_rst)
    $changed(state_reg.abort_db) |-> $past(abort_button) ==
    state_reg.abort_db)
    else $error("abort accepted without raw level");
  // Lone soft press always starts a soft pulse
  chk_soft_start: assert property (
    @(posedge clock) disable iff (sys_rst)
    state_reg.state == ST_IDLE && state_reg.soft_db &&
    !state_reg.abort_db |=> !soft_reset_n)
    else $error("soft reset not issued");
  // Lone abort press always raises the request
  chk_irq_nomask: assert property (
    @(posedge clock) disable iff (sys_rst)
    state_reg.state == ST_IDLE && state_reg.abort_db &&
    !state_reg.soft_db |=> !abort_irq0_n)
    else $error("abort irq missing");

  // Checks on indicators, chip selects and buffers
  // Run lamp dark whenever the selected debug source shows debug
  chk_run_lamp: assert property (
    @(posedge clock) disable iff (sys_rst)
    run_indicator |-> (debug_source_jumper == JUMPER_FREEZE) ? !freeze_line :
    (!debug_status_line_a && !debug_status_line_b))
    else $error("run lamp lit in debug mode");
  // Auxiliary lamp follows its register bit only
  chk_aux_lamp: assert property (
    @(posedge clock) disable iff (sys_rst)
    auxiliary_indicator == signal_lamp)
    else $error("aux lamp differs from lamp bit");
  // Disabled flash releases its select and darkens its lamp
  chk_flash_off: assert property (
    @(posedge clock) disable iff (sys_rst)
    !flash_enable |-> chip_select_flash_n && !flash_indicator)
    else $error("flash select active while disabled");
  // Disabled DRAM releases both selects and darkens its lamp
  chk_dram_off: assert property (
    @(posedge clock) disable iff (sys_rst)
    !dram_enable |-> chip_select_dram_a_n && chip_select_dram_b_n &&
    !dram_indicator)
    else $error("dram select active while disabled");
  // Disabled SDRAM releases its select and darkens its lamp
  chk_sdram_off: assert property (
    @(posedge clock) disable iff (sys_rst)
    !sdram_enable |-> chip_select_sdram_n && !sdram_indicator)
    else $error("sdram select active while disabled");
  // Enabled card channel drives address and status, lamp lit
  chk_card_on: assert property (
    @(posedge clock) disable iff (sys_rst)
    pcmcia_enable |-> !card_addr_buf_oe_n && !card_status_buf_oe_n &&
    pcmcia_indicator)
    else $error("card buffers idle while enabled");
  // Data buffers only open during a card strobe
  chk_card_data: assert property (
    @(posedge clock) disable iff (sys_rst)
    !card_data_buf_oe_n |-> pcmcia_enable &&
    (!card_enable_low_n || !card_enable_high_n))
    else $error("card data driven without strobe");
  // Disabled card channel leaves every buffer off, lamp dark
  chk_card_off: assert property (
    @(posedge clock) disable iff (sys_rst)
    !pcmcia_enable |-> card_addr_buf_oe_n && card_data_buf_oe_n &&
    card_status_buf_oe_n && !pcmcia_indicator)
    else $error("card buffers driven while disabled");
  // Each transceiver either runs with lamp lit or sleeps dark
  chk_xcvr_state: assert property (
    @(posedge clock) disable iff (sys_rst)
    xcvr_shutdown == ~xcvr_enable && xcvr_indicator == xcvr_enable)
    else $error("transceiver shutdown or lamp wrong");

  // Main scenarios that the bench is expected to reach
  cov_soft: cover property (@(posedge clock) $rose(soft_reset_n));
  cov_hard: cover property (@(posedge clock) $rose(hard_reset_n));
  cov_abort: cover property (@(posedge clock) $fell(abort_irq0_n));
  cov_card_data: cover property (@(posedge clock) !card_data_buf_oe_n);
endmodule : board_switch_reset_indicator_ctrl

// [cpu_model.sv]
// Processor-side model: selects, card strobes, config capture
`timescale 1ns/10ps
module cpu_model
  import board_ctrl_pkg::*;
(
  input wire logic clock,
  input wire logic [7:0] pattern,
  input wire logic soft_reset_n,
  input wire logic hard_reset_n,
  input wire logic config_valid,
  input wire logic [CONFIG_W-1:0] config_word,
  output logic cs0_cpu_n,
  output logic cs2_cpu_n,
  output logic cs3_cpu_n,
  output logic cs4_cpu_n,
  output logic card_enable_low_n,
  output logic card_enable_high_n,
  output logic card_write_n,
  output logic [CONFIG_W-1:0] sampled_cfg
);
  logic in_reset; // Core held in either reset
  assign in_reset = !soft_reset_n || !hard_reset_n;
  // A core in reset never drives its selects, so all stay inactive
  always_comb begin
    {cs0_cpu_n, cs2_cpu_n, cs3_cpu_n, cs4_cpu_n, card_enable_low_n,
     card_enable_high_n, card_write_n} = in_reset ? 7'h7F : pattern[6:0];
  end
  // Configuration taken only once the sequence has ended
  always @(posedge clock) begin
    if (!in_reset && config_valid) begin
      sampled_cfg <= config_word;
    end
  end
endmodule : cpu_model

// [testbench.sv]
// Self-checking bench for the board control block
`timescale 1ns/10ps
module testbench;
  import board_ctrl_pkg::*;
  localparam int DB = 4; // Short debounce for simulation
  localparam int PL = 8; // Short reset pulse
  logic clock = 1'h0;
  logic sys_rst = 1'h1;
  logic abort_button = 1'h0, soft_reset_button = 1'h0;
  logic debug_status_line_a, debug_status_line_b, freeze_line;
  logic debug_source_jumper, flash_enable, dram_enable, sdram_enable;
  logic pcmcia_enable, signal_lamp;
  logic [3:0] xcvr_enable, software_option_switches, option_switch_lines;
  logic [7:0] pattern;
  logic [31:0] board_ctrl_reg_first = 32'h5A3C9E71;
  logic [31:0] soft_config_word = 32'h1F2E3D4C;
  logic [31:0] config_word, sampled_cfg;
  logic cs0_cpu_n, cs2_cpu_n, cs3_cpu_n, cs4_cpu_n, card_write_n;
  logic card_enable_low_n, card_enable_high_n;
  logic abort_irq0_n, soft_reset_n, hard_reset_n, config_valid;
  logic chip_select_flash_n, chip_select_dram_a_n, chip_select_dram_b_n;
  logic chip_select_sdram_n, card_addr_buf_oe_n, card_status_buf_oe_n;
  logic card_data_buf_oe_n, card_data_to_card;
  logic [3:0] xcvr_shutdown, xcvr_indicator;
  logic run_indicator, auxiliary_indicator, flash_indicator;
  logic dram_indicator, sdram_indicator, pcmcia_indicator;
  logic [31:0] seed = 32'h000134BA; // Random source starts at 79034
  logic [33:0] expq[$]; // Expected events: kind and config word
  logic [33:0] note;
  logic [1:0] ev;
  logic prev_irq = 1'h1, prev_soft = 1'h1, prev_hard = 1'h1;
  int err_count = 0;
  int checked = 0;

  board_switch_reset_indicator_ctrl #(.DEBOUNCE_LEN(DB), .PULSE_LEN(PL))
    u_board_switch_reset_indicator_ctrl (.*);
  cpu_model u_cpu_model (.*);

  // Free-running board clock
  always #12.5 clock = ~clock;

  // Shift register used for all random stimulus
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  // Compare one value and keep score
  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // Random levels on every static input except the two config words, then the routed outputs
  task automatic rand_step;
    logic [31:0] e, s;
    @(negedge clock);
    seed = lfsr(seed);
    {flash_enable, dram_enable, sdram_enable, pcmcia_enable, signal_lamp,
     debug_status_line_a, debug_status_line_b, freeze_line,
     debug_source_jumper, xcvr_enable, pattern,
     software_option_switches} = seed[24:0];
    #1;
    e = {flash_enable ? cs0_cpu_n : 1'h1, dram_enable ? cs2_cpu_n : 1'h1,
         dram_enable ? cs3_cpu_n : 1'h1, sdram_enable ? cs4_cpu_n : 1'h1};
    s = {chip_select_flash_n, chip_select_dram_a_n, chip_select_dram_b_n,
         chip_select_sdram_n};
    check("selects", s, e);
    s = {flash_indicator, dram_indicator, sdram_indicator, pcmcia_indicator};
    check("lamps", s, {flash_enable, dram_enable, sdram_enable, pcmcia_enable});
    check("aux", auxiliary_indicator, signal_lamp);
    e = debug_source_jumper ? freeze_line : debug_status_line_a | debug_status_line_b;
    check("run", run_indicator, !e[0]);
    e = {!pcmcia_enable, !pcmcia_enable,
         !(pcmcia_enable && !(card_enable_low_n && card_enable_high_n))};
    s = {card_addr_buf_oe_n, card_status_buf_oe_n, card_data_buf_oe_n};
    check("card_oe", s, e);
    check("card_dir", card_data_to_card, !card_write_n);
    check("xcvr", {xcvr_shutdown, xcvr_indicator}, {~xcvr_enable, xcvr_enable});
    @(posedge clock);
    #1;
    check("options", option_switch_lines, software_option_switches);
  endtask : rand_step

  // Hold the buttons for a number of cycles, note what must follow
  task automatic press(input logic ab, input logic sb, input int hold,
                       input logic [1:0] kind, input logic [31:0] cfg);
    if (kind != 2'h0) expq.push_back({kind, cfg});
    @(negedge clock);
    abort_button = ab;
    soft_reset_button = sb;
    repeat (hold) @(negedge clock);
    abort_button = 1'h0;
    soft_reset_button = 1'h0;
    repeat (PL + 3 * DB + 6) @(negedge clock);
    if (kind[1]) check("cpu_cfg", sampled_cfg, cfg);
  endtask : press

  // Watches the outputs and matches each event with the oldest note
  always @(posedge clock) begin
    #1;
    if (!sys_rst) begin
      ev = 2'h0;
      if (prev_irq && !abort_irq0_n) ev = 2'h1;
      if (!prev_soft && soft_reset_n) ev = 2'h2;
      if (!prev_hard && hard_reset_n) ev = 2'h3;
      if (prev_soft && !soft_reset_n) check("valid_low", config_valid, 1'h0);
      if (ev != 2'h0 && expq.size() == 0) begin
        check("unexpected", {30'h0, ev}, 32'h0);
      end else if (ev != 2'h0) begin
        note = expq.pop_front();
        check("event", {30'h0, ev}, {30'h0, note[33:32]});
        if (ev[1]) check("cfg", config_word, note[31:0]);
        if (ev[1]) check("valid", config_valid, 1'h1);
      end
    end
    prev_irq = abort_irq0_n;
    prev_soft = soft_reset_n;
    prev_hard = hard_reset_n;
  end

  // Main sequence
  initial begin
    {debug_status_line_a, debug_status_line_b, freeze_line} = 3'h0;
    {debug_source_jumper, flash_enable, dram_enable} = 3'h0;
    {sdram_enable, pcmcia_enable, signal_lamp} = 3'h0;
    xcvr_enable = 4'h0;
    software_option_switches = 4'h0;
    pattern = 8'hFF;
    repeat (20) @(negedge clock);
    sys_rst = 1'h0;
    repeat (24) rand_step();
    press(1'h1, 1'h0, DB - 1, 2'h0, 32'h0);
    press(1'h0, 1'h1, DB - 1, 2'h0, 32'h0);
    press(1'h1, 1'h0, 12, 2'h1, 32'h0);
    press(1'h0, 1'h1, 12, 2'h2, soft_config_word);
    press(1'h1, 1'h1, 12, 2'h3, board_ctrl_reg_first);
    press(1'h0, 1'h1, 12, 2'h2, soft_config_word);
    repeat (8) rand_step();
    check("pending", expq.size(), 32'h0);
    conclude();
  end

  // Cut a hang short
  initial begin
    #(25 * 6000);
    err_count++;
    conclude();
  end

  // Report and end the run
  task automatic conclude;
    $display("Checks %0d errors %0d", checked, err_count);
    if (err_count == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : conclude
endmodule : testbench
